//--- mss_sweep_seq.sv
// modulation oscillator control and stepped sweep sequencer with wishbone slave
// assumes a single 250 MHz clock; rear-panel and knob inputs are asynchronous
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`default_nettype none
module mss_sweep_seq #(
  parameter int unsigned FW        = 20,
  parameter int unsigned IW        = 16,
  parameter int unsigned BLANK_CYC = mss_pkg::BLANK_CYC
) (
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  input  wire logic          i_ce,
  input  wire logic          i_wb_cyc,
  input  wire logic          i_wb_stb,
  input  wire logic          i_wb_we,
  input  wire logic [7:0]    i_wb_adr,
  input  wire logic [3:0]    i_wb_sel,
  input  wire logic [31:0]   i_wb_dat,
  output logic      [31:0]   o_wb_dat,
  output logic               o_wb_ack,
  input  wire logic          i_aux_manual_n,
  input  wire logic          i_aux_auto_n,
  input  wire logic          i_aux_single_n,
  input  wire logic          i_knob_cw,
  input  wire logic          i_knob_ccw,
  output logic               o_mod_osc_output,
  output logic      [FW-1:0] o_mod_rate_entry,
  output logic      [IW-1:0] o_staircase_output,
  output logic               o_step_blank_output,
  output logic               o_pen_raise_output,
  output logic               o_sweep_end_n,
  output logic               o_irq
);
  localparam int unsigned END_CYC = mss_pkg::END_CYC;
  localparam int unsigned AUX_CYC = mss_pkg::AUX_MIN_CYC;

  if (FW != 20 || IW < 8 || BLANK_CYC < 2) begin : g_bad_param
    $error("mss_sweep_seq: FW must be 20, IW at least 8, BLANK_CYC at least 2");
  end

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // one step away from f, clamped to the oscillator range
  function automatic logic [19:0] next_freq(input logic [19:0] f, input logic up, input logic lg,
                                            input logic pct1, input logic [19:0] lin);
    logic [19:0] d;
    logic [20:0] s;
    d = lg ? (pct1 ? f / 20'd100 : f / 20'd10) : lin;
    if (d == 20'h0_0000) begin
      d = 20'h0_0001;
    end
    s = up ? ({1'b0, f} + {1'b0, d}) : ({1'b0, f} - {1'b0, d});
    if (!up && (f < d || s[19:0] < mss_pkg::FREQ_MIN)) begin
      s = {1'b0, mss_pkg::FREQ_MIN};
    end else if (up && s > {1'b0, mss_pkg::FREQ_MAX}) begin
      s = {1'b0, mss_pkg::FREQ_MAX};
    end
    return s[19:0];
  endfunction

  // bus decode
  logic        ack_q;
  logic        req;
  logic        wr;
  logic [5:0]  widx;
  assign req  = i_wb_cyc & i_wb_stb & ~ack_q;
  assign wr   = req & i_wb_we;
  assign widx = i_wb_adr[7:2];

  logic        spec_stb;
  logic        cmd_stb;
  logic        host_stb;
  assign spec_stb = wr & (widx == mss_pkg::OFF_SPECIAL) & i_wb_sel[0];
  assign cmd_stb  = wr & (widx == mss_pkg::OFF_SWP_CMD) & i_wb_sel[0];
  assign host_stb = wr & (widx == mss_pkg::OFF_HOST_STP) & i_wb_sel[0] & i_wb_dat[0];

  // rear-panel and knob synchronisers
  logic [4:0] pin_raw;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] sync3_q;
  assign pin_raw = {i_knob_ccw, i_knob_cw, i_aux_single_n, i_aux_auto_n, i_aux_manual_n};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= 5'h07;
      sync2_q <= 5'h07;
      sync3_q <= 5'h07;
    end else if (i_ce) begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic knob_up;
  logic knob_dn;
  assign knob_up = sync2_q[3] & ~sync3_q[3];
  assign knob_dn = sync2_q[4] & ~sync3_q[4];

  // low-true mode pulses qualify once they have stayed low for the minimum width
  logic [2:0] aux_fire;
  for (genvar g = 0; g < 3; g++) begin : g_aux
    logic [$clog2(AUX_CYC+1)-1:0] cnt_q;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        cnt_q <= '0;
      end else if (i_ce) begin
        if (sync2_q[g]) begin
          cnt_q <= '0;
        end else if (cnt_q != AUX_CYC[$clog2(AUX_CYC+1)-1:0]) begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
    // fires once per pulse, shorter glitches are ignored
    assign aux_fire[g] = ~sync2_q[g] & (cnt_q == AUX_CYC[$clog2(AUX_CYC+1)-1:0] - 1'b1);
  end

  // enable and oscillator state
  logic sw_en_q;
  logic osc_on_q;
  logic [2:0] cfg_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sw_en_q <= 1'b0;
    end else if (i_ce && spec_stb) begin
      if (i_wb_dat[7:0] == mss_pkg::SF_SWP_EN) begin
        sw_en_q <= 1'b1;
      end else if (i_wb_dat[7:0] == mss_pkg::SF_SWP_DIS) begin
        sw_en_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      osc_on_q <= 1'b0;
    end else if (i_ce && spec_stb) begin
      if (i_wb_dat[7:0] == mss_pkg::SF_OSC_ON && !cfg_q[mss_pkg::CFG_MODACT]) begin
        osc_on_q <= 1'b1;
      end else if (i_wb_dat[7:0] == mss_pkg::SF_ALL_OFF || i_wb_dat[7:0] == mss_pkg::SF_OSC_OFF) begin
        osc_on_q <= 1'b0;
      end
    end
  end

  // sweep parameters; kept across mode changes, cleared only by code 40
  logic [19:0] start_q;
  logic [19:0] stop_q;
  logic [19:0] step_q;
  logic [19:0] fixed_q;
  logic [31:0] dwell_q;
  logic        sys_clear;
  assign sys_clear = spec_stb & (i_wb_dat[7:0] == mss_pkg::SF_SWP_DIS);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_q <= mss_pkg::DEF_START;
      stop_q  <= mss_pkg::DEF_STOP;
      step_q  <= mss_pkg::DEF_STEP;
      fixed_q <= mss_pkg::DEF_FIXED;
      dwell_q <= mss_pkg::DEF_DWELL;
      cfg_q   <= mss_pkg::DEF_CONFIG;
    end else if (i_ce) begin
      if (sys_clear) begin
        start_q <= mss_pkg::DEF_START;
        stop_q  <= mss_pkg::DEF_STOP;
        step_q  <= mss_pkg::DEF_STEP;
        fixed_q <= mss_pkg::DEF_FIXED;
        dwell_q <= mss_pkg::DEF_DWELL;
        cfg_q   <= {cfg_q[mss_pkg::CFG_MODACT], 2'b00};
      end else if (wr) begin
        case (widx)
          mss_pkg::OFF_CONFIG: cfg_q   <= 3'(merge({29'h0, cfg_q}, i_wb_dat, i_wb_sel));
          mss_pkg::OFF_START:  start_q <= 20'(merge({12'h0, start_q}, i_wb_dat, i_wb_sel));
          mss_pkg::OFF_STOP:   stop_q  <= 20'(merge({12'h0, stop_q}, i_wb_dat, i_wb_sel));
          mss_pkg::OFF_STEP:   step_q  <= 20'(merge({12'h0, step_q}, i_wb_dat, i_wb_sel));
          mss_pkg::OFF_FIXED:  fixed_q <= 20'(merge({12'h0, fixed_q}, i_wb_dat, i_wb_sel));
          mss_pkg::OFF_DWELL:  dwell_q <= merge(dwell_q, i_wb_dat, i_wb_sel);
          default: ;
        endcase
      end
    end
  end

  // mode requests from bus and rear panel
  logic req_cancel;
  logic req_auto;
  logic req_manual;
  logic req_single;
  logic req_host;
  assign req_cancel = cmd_stb & (i_wb_dat[2:0] == mss_pkg::CMD_CANCEL);
  assign req_auto   = (cmd_stb & (i_wb_dat[2:0] == mss_pkg::CMD_AUTO)) | aux_fire[1];
  assign req_manual = (cmd_stb & (i_wb_dat[2:0] == mss_pkg::CMD_MANUAL)) | aux_fire[0];
  assign req_single = (cmd_stb & (i_wb_dat[2:0] == mss_pkg::CMD_SINGLE)) | aux_fire[2];
  assign req_host   = cmd_stb & (i_wb_dat[2:0] == mss_pkg::CMD_HOST);

  // sweep engine
  mss_pkg::mss_mode_e mode_q;
  logic [19:0]        freq_q;
  logic [IW-1:0]      idx_q;
  logic               resume_q;
  logic               step_evt_q;
  logic               end_evt_q;
  logic [31:0]        dwell_cnt_q;
  logic               up;
  logic               step_due;
  logic               adv;
  logic [19:0]        nxt;
  logic               past_end;

  assign up       = stop_q >= start_q;
  assign step_due = (mode_q == mss_pkg::MD_AUTO || mode_q == mss_pkg::MD_SINGLE) &&
                    (dwell_cnt_q + 32'h0000_0001 >= dwell_q);
  assign adv      = step_due | (mode_q == mss_pkg::MD_HOST && host_stb);
  assign nxt      = next_freq(freq_q, up, cfg_q[mss_pkg::CFG_LOG], cfg_q[mss_pkg::CFG_LOG1PCT], step_q);
  assign past_end = up ? (nxt > stop_q || freq_q >= stop_q) : (nxt < stop_q || freq_q <= stop_q);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dwell_cnt_q <= 32'h0000_0000;
    end else if (i_ce) begin
      if (adv || step_evt_q || !(mode_q == mss_pkg::MD_AUTO || mode_q == mss_pkg::MD_SINGLE)) begin
        dwell_cnt_q <= 32'h0000_0000;
      end else begin
        dwell_cnt_q <= dwell_cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q     <= mss_pkg::MD_OFF;
      freq_q     <= mss_pkg::DEF_FIXED;
      idx_q      <= '0;
      resume_q   <= 1'b0;
      step_evt_q <= 1'b0;
      end_evt_q  <= 1'b0;
    end else if (i_ce) begin
      step_evt_q <= 1'b0;
      end_evt_q  <= 1'b0;
      if (!sw_en_q || sys_clear || req_cancel) begin
        // disabled or cancelled: idle at the fixed frequency
        mode_q   <= mss_pkg::MD_OFF;
        freq_q   <= fixed_q;
        idx_q    <= '0;
        resume_q <= 1'b0;
      end else if (req_manual) begin
        mode_q <= mss_pkg::MD_MANUAL;
        if (mode_q == mss_pkg::MD_AUTO || mode_q == mss_pkg::MD_SINGLE) begin
          resume_q <= 1'b1;
        end else if (mode_q != mss_pkg::MD_MANUAL) begin
          freq_q     <= start_q;
          idx_q      <= '0;
          step_evt_q <= 1'b1;
        end
      end else if (req_auto || req_single) begin
        mode_q   <= req_auto ? mss_pkg::MD_AUTO : mss_pkg::MD_SINGLE;
        resume_q <= 1'b0;
        if (!resume_q) begin
          freq_q     <= start_q;
          idx_q      <= '0;
          step_evt_q <= 1'b1;
        end
      end else if (req_host) begin
        mode_q     <= mss_pkg::MD_HOST;
        resume_q   <= 1'b0;
        freq_q     <= start_q;
        idx_q      <= '0;
        step_evt_q <= 1'b1;
      end else if (adv) begin
        step_evt_q <= 1'b1;
        if (past_end) begin
          end_evt_q <= 1'b1;
          idx_q     <= '0;
          if (mode_q == mss_pkg::MD_SINGLE) begin
            mode_q     <= mss_pkg::MD_OFF;
            freq_q     <= fixed_q;
            step_evt_q <= 1'b0;
          end else begin
            freq_q <= start_q;
          end
        end else begin
          freq_q <= nxt;
          idx_q  <= idx_q + 1'b1;
        end
      end else if (mode_q == mss_pkg::MD_MANUAL && (knob_up ^ knob_dn)) begin
        // knob walks the staircase: cw no further than stop, ccw no further than step 0
        step_evt_q <= 1'b1;
        if (knob_up && !past_end) begin
          freq_q <= nxt;
          idx_q  <= idx_q + 1'b1;
        end else if (knob_dn && idx_q != '0) begin
          freq_q <= (next_freq(freq_q, !up, cfg_q[mss_pkg::CFG_LOG], cfg_q[mss_pkg::CFG_LOG1PCT], step_q)
                     == freq_q) ? start_q
                    : next_freq(freq_q, !up, cfg_q[mss_pkg::CFG_LOG], cfg_q[mss_pkg::CFG_LOG1PCT], step_q);
          idx_q  <= idx_q - 1'b1;
        end else begin
          step_evt_q <= 1'b0;
        end
      end
    end
  end

  // rear outputs; the blanking line never carries markers here
  logic [$clog2(BLANK_CYC+1)-1:0] blank_cnt_q;
  logic [$clog2(END_CYC+1)-1:0]   end_cnt_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      blank_cnt_q         <= '0;
      o_step_blank_output <= 1'b0;
    end else if (i_ce) begin
      if (step_evt_q) begin
        blank_cnt_q         <= BLANK_CYC[$clog2(BLANK_CYC+1)-1:0];
        o_step_blank_output <= 1'b1;
      end else if (blank_cnt_q != '0) begin
        blank_cnt_q         <= blank_cnt_q - 1'b1;
        o_step_blank_output <= (blank_cnt_q != 1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      end_cnt_q     <= '0;
      o_sweep_end_n <= 1'b1;
    end else if (i_ce) begin
      if (end_evt_q) begin
        end_cnt_q     <= END_CYC[$clog2(END_CYC+1)-1:0];
        o_sweep_end_n <= 1'b0;
      end else if (end_cnt_q != '0) begin
        end_cnt_q     <= end_cnt_q - 1'b1;
        o_sweep_end_n <= (end_cnt_q == 1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pen_raise_output <= 1'b1;
      o_mod_osc_output   <= 1'b0;
      o_mod_rate_entry         <= mss_pkg::DEF_FIXED;
      o_staircase_output <= '0;
    end else if (i_ce) begin
      o_pen_raise_output <= (mode_q != mss_pkg::MD_SINGLE);
      o_mod_osc_output   <= osc_on_q | cfg_q[mss_pkg::CFG_MODACT] | (mode_q != mss_pkg::MD_OFF);
      o_mod_rate_entry         <= freq_q;
      o_staircase_output <= idx_q;
    end
  end

  // interrupts: sticky, write one to clear, set wins
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set = {|aux_fire, end_evt_q, step_evt_q};
  assign irq_clr = (wr && widx == mss_pkg::OFF_IRQ_STAT && i_wb_sel[0]) ? i_wb_dat[2:0] : 3'h0;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      o_irq      <= 1'b0;
    end else if (i_ce) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (wr && widx == mss_pkg::OFF_IRQ_MASK && i_wb_sel[0]) begin
        irq_mask_q <= i_wb_dat[2:0];
      end
      o_irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read mux and single-cycle ack; unmapped reads return zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (widx)
      mss_pkg::OFF_CONFIG:   rd_mux = {29'h0, cfg_q};
      mss_pkg::OFF_START:    rd_mux = {12'h0, start_q};
      mss_pkg::OFF_STOP:     rd_mux = {12'h0, stop_q};
      mss_pkg::OFF_STEP:     rd_mux = {12'h0, step_q};
      mss_pkg::OFF_DWELL:    rd_mux = dwell_q;
      mss_pkg::OFF_FIXED:    rd_mux = {12'h0, fixed_q};
      mss_pkg::OFF_STATUS:   rd_mux = {25'h0, resume_q, mode_q, (mode_q == mss_pkg::MD_SINGLE), osc_on_q, sw_en_q};
      mss_pkg::OFF_CUR_FREQ: rd_mux = {12'h0, freq_q};
      mss_pkg::OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
      mss_pkg::OFF_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_q    <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce) begin
      ack_q <= req;
      if (req && !i_wb_we) begin
        o_wb_dat <= rd_mux;
      end
    end
  end
  assign o_wb_ack = ack_q;
endmodule
`default_nettype wire

//--- mss_pkg.sv
// package for the modulation sweep sequencer: offsets, codes, defaults, timing
// assumes a 250 MHz system clock; frequencies are held in 0.1 Hz units
`default_nettype none
package mss_pkg;
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned BLANK_US     = 250;
  localparam int unsigned BLANK_CYC    = BLANK_US * CLK_MHZ;
  localparam int unsigned END_US       = 5;
  localparam int unsigned END_CYC      = END_US * CLK_MHZ;
  localparam int unsigned AUX_MIN_US   = 5;
  localparam int unsigned AUX_MIN_CYC  = AUX_MIN_US * CLK_MHZ;

  localparam logic [5:0]  OFF_SPECIAL  = 6'h00;
  localparam logic [5:0]  OFF_SWP_CMD  = 6'h01;
  localparam logic [5:0]  OFF_CONFIG   = 6'h02;
  localparam logic [5:0]  OFF_START    = 6'h03;
  localparam logic [5:0]  OFF_STOP     = 6'h04;
  localparam logic [5:0]  OFF_STEP     = 6'h05;
  localparam logic [5:0]  OFF_DWELL    = 6'h06;
  localparam logic [5:0]  OFF_FIXED    = 6'h07;
  localparam logic [5:0]  OFF_STATUS   = 6'h08;
  localparam logic [5:0]  OFF_CUR_FREQ = 6'h09;
  localparam logic [5:0]  OFF_IRQ_STAT = 6'h0A;
  localparam logic [5:0]  OFF_IRQ_MASK = 6'h0B;
  localparam logic [5:0]  OFF_HOST_STP = 6'h0C;

  localparam logic [7:0]  SF_ALL_OFF   = 8'h00;
  localparam logic [7:0]  SF_SWP_DIS   = 8'h28;
  localparam logic [7:0]  SF_SWP_EN    = 8'h29;
  localparam logic [7:0]  SF_OSC_OFF   = 8'h60;
  localparam logic [7:0]  SF_OSC_ON    = 8'h61;

  localparam logic [2:0]  CMD_CANCEL   = 3'h1;
  localparam logic [2:0]  CMD_AUTO     = 3'h2;
  localparam logic [2:0]  CMD_MANUAL   = 3'h3;
  localparam logic [2:0]  CMD_SINGLE   = 3'h4;
  localparam logic [2:0]  CMD_HOST     = 3'h5;

  localparam int unsigned CFG_LOG      = 0;
  localparam int unsigned CFG_LOG1PCT  = 1;
  localparam int unsigned CFG_MODACT   = 2;

  localparam int unsigned IRQ_STEP     = 0;
  localparam int unsigned IRQ_END      = 1;
  localparam int unsigned IRQ_AUX      = 2;

  localparam logic [19:0] FREQ_MIN     = 20'h0_0064;
  localparam logic [19:0] FREQ_MAX     = 20'hF_3E58;
  localparam logic [19:0] DEF_START    = 20'h0_03E8;
  localparam logic [19:0] DEF_STOP     = 20'h0_2710;
  localparam logic [19:0] DEF_STEP     = 20'h0_0064;
  localparam logic [19:0] DEF_FIXED    = 20'h0_2710;
  localparam logic [31:0] DEF_DWELL    = 32'h0000_F424;
  localparam logic [2:0]  DEF_CONFIG   = 3'h0;

  typedef enum logic [2:0] {MD_OFF, MD_AUTO, MD_MANUAL, MD_SINGLE, MD_HOST} mss_mode_e;
endpackage
`default_nettype wire

//--- mss_sweep_seq_sva.sv
// port checker for the sweep sequencer, bound into every instance
// assumes one clock domain with an asynchronous active-low reset
`default_nettype none
module mss_sweep_seq_sva #(
  parameter int unsigned BLANK_CYC = 62500,
  parameter int unsigned IW        = 16
) (
  input wire logic          i_clk,
  input wire logic          i_arst_n,
  input wire logic          i_ce,
  input wire logic          i_wb_cyc,
  input wire logic          i_wb_stb,
  input wire logic          i_wb_we,
  input wire logic [31:0]   o_wb_dat,
  input wire logic          o_wb_ack,
  input wire logic          o_mod_osc_output,
  input wire logic [IW-1:0] o_staircase_output,
  input wire logic          o_step_blank_output,
  input wire logic          o_sweep_end_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] end_cnt_q;
  logic [31:0] blk_cnt_q;
  wire logic   take;
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce;
  // pulse widths counted here: too long for a repetition operator
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      end_cnt_q <= '0;
      blk_cnt_q <= '0;
    end else begin
      end_cnt_q <= o_sweep_end_n ? '0 : end_cnt_q + 1;
      blk_cnt_q <= o_step_blank_output ? blk_cnt_q + 1 : '0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  ack_timing_a: assert property (take |=> o_wb_ack) else $error("ack late");
  ack_single_a: assert property (o_wb_ack && i_ce |=> !o_wb_ack) else $error("ack too long");
  ack_cause_a: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
  rdata_hold_a: assert property ($changed(o_wb_dat) |-> o_wb_ack && !$past(i_wb_we)) else $error("read data moved");
  end_width_a: assert property ($rose(o_sweep_end_n) |-> end_cnt_q == mss_pkg::END_CYC) else $error("end width");
  blank_width_a: assert property ($fell(o_step_blank_output) |-> blk_cnt_q == BLANK_CYC) else $error("blank width");
  step_blank_a: assert property ($changed(o_staircase_output) && o_staircase_output != '0
    |-> ##[0:2] o_step_blank_output) else $error("step without blank");
  osc_off_a: assert property ($fell(o_mod_osc_output)
    |-> $past(take && i_wb_we) || $past(take && i_wb_we, 2)) else $error("osc dropped unasked");
  cover property ($fell(o_sweep_end_n));
  cover property ($rose(o_step_blank_output));
  cover property ($fell(o_mod_osc_output));
endmodule
bind mss_sweep_seq mss_sweep_seq_sva #(.BLANK_CYC(BLANK_CYC), .IW(IW)) u_sva (.i_clk, .i_arst_n, .i_ce, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .o_wb_dat, .o_wb_ack, .o_mod_osc_output, .o_staircase_output, .o_step_blank_output,
  .o_sweep_end_n);
`default_nettype wire

//--- mss_rear_model.sv
// rear-panel equipment: low-true mode pulses of a chosen length
// assumes a one-cycle pick request, spaced past the previous pulse
`default_nettype none
module mss_rear_model (
  input  wire logic        i_clk,
  input  wire logic [2:0]  i_pick,
  input  wire logic [15:0] i_len,
  output logic             o_manual_n,
  output logic             o_auto_n,
  output logic             o_single_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q = '0;
  logic [2:0]  act_q = '0;
  always_ff @(posedge i_clk) begin
    if (cnt_q != '0)
      cnt_q <= cnt_q - 1;
    else if (i_pick != '0) begin
      cnt_q <= i_len;
      act_q <= i_pick;
    end
  end
  // idle lines rest high like pulled-up inputs; short lengths probe the filter
  assign o_manual_n = !(act_q[0] && cnt_q != '0);
  assign o_auto_n   = !(act_q[1] && cnt_q != '0);
  assign o_single_n = !(act_q[2] && cnt_q != '0);
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench: wishbone tasks, rear pulses, knob clicks
// assumes 250 MHz clock; blank shortened to 20 cycles for run time
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 0, i_arst_n = 0, cyc = 0, we = 0, cw = 0, ccw = 0, ack, osc, blank, pen, endn, irq;
  logic        am_n, aa_n, as_n;
  logic [7:0]  adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [2:0]  pick = '0;
  logic [15:0] plen = '0, stair;
  logic [19:0] f0, freq;
  logic [7:0]  offc [2] = '{mss_pkg::SF_OSC_OFF, mss_pkg::SF_ALL_OFF};
  int          errors = 0, compares = 0, blanks = 0;
  initial forever #2 i_clk = ~i_clk;
  always @(posedge blank) blanks++;
  mss_sweep_seq #(.BLANK_CYC(20)) DUT (.i_clk, .i_arst_n, .i_ce(1'h1), .i_wb_cyc(cyc), .i_wb_stb(cyc),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_aux_manual_n(am_n), .i_aux_auto_n(aa_n), .i_aux_single_n(as_n), .i_knob_cw(cw), .i_knob_ccw(ccw),
    .o_mod_osc_output(osc), .o_mod_rate_entry(freq), .o_staircase_output(stair), .o_step_blank_output(blank),
    .o_pen_raise_output(pen), .o_sweep_end_n(endn), .o_irq(irq));
  mss_rear_model rear (.i_clk, .i_pick(pick), .i_len(plen), .o_manual_n(am_n), .o_auto_n(aa_n), .o_single_n(as_n));
  task automatic complete_run();
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // wishbone classic cycle; stb rides on cyc, so both rise and fall together
  task automatic bus(input logic w, input logic [5:0] off, input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'h1;
    we <= w;
    adr <= {off, 2'h0};
    wdat <= d;
    do @(posedge i_clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    repeat (3) @(negedge i_clk);
  endtask
  task automatic wr(input logic [5:0] off, input logic [31:0] d);
    bus(1'h1, off, d);
  endtask
  task automatic rd(input logic [5:0] off, input string n, input logic [31:0] e);
    bus(1'h0, off, '0);
    chk(n, e, q);
  endtask
  task automatic wait_end();
    for (int n = 0; n < 2000 && endn !== 1'h1; n++) @(negedge i_clk);
    for (int n = 0; n < 2000 && endn !== 1'h0; n++) @(negedge i_clk);
    repeat (3) @(negedge i_clk);
  endtask
  task automatic knob(input logic up);
    @(posedge i_clk);
    if (up) cw <= 1'h1; else ccw <= 1'h1;
    repeat (4) @(posedge i_clk);
    cw <= 1'h0;
    ccw <= 1'h0;
    // clicks spaced past one blanking pulse
    repeat (24) @(negedge i_clk);
  endtask
  task automatic rear_pulse(input logic [2:0] p, input logic [15:0] len);
    @(posedge i_clk);
    pick <= p;
    plen <= len;
    @(posedge i_clk);
    pick <= '0;
    repeat (int'(len) + 20) @(posedge i_clk);
    bus(1'h0, mss_pkg::OFF_STATUS, '0);
  endtask
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'h1;
    @(negedge i_clk);
    chk("reset freq", mss_pkg::DEF_FIXED, freq);
    chk("reset pen", 1'h1, pen);
    chk("reset end", 1'h1, endn);
    rd(mss_pkg::OFF_DWELL, "dwell", mss_pkg::DEF_DWELL);
    rd(6'h3F, "unmapped", '0);
    foreach (offc[i]) begin
      wr(mss_pkg::OFF_SPECIAL, mss_pkg::SF_OSC_ON);
      chk("osc on", 1'h1, osc);
      wr(mss_pkg::OFF_SPECIAL, offc[i]);
      chk("osc off", 1'h0, osc);
    end
    wr(mss_pkg::OFF_CONFIG, 32'h4);
    chk("osc modact", 1'h1, osc);
    wr(mss_pkg::OFF_CONFIG, '0);
    wr(mss_pkg::OFF_SWP_CMD, mss_pkg::CMD_AUTO);
    rd(mss_pkg::OFF_STATUS, "status off", '0);
    wr(mss_pkg::OFF_SPECIAL, mss_pkg::SF_SWP_EN);
    // oscillator kept on so that a finished single sweep does not drop the connector
    wr(mss_pkg::OFF_SPECIAL, mss_pkg::SF_OSC_ON);
    wr(mss_pkg::OFF_STOP, 20'h0_0514);
    // sweep must outlast the end pulse, or pulses merge
    wr(mss_pkg::OFF_DWELL, 32'h0000_0190);
    wr(mss_pkg::OFF_IRQ_MASK, 32'h2);
    blanks = 0;
    wr(mss_pkg::OFF_SWP_CMD, mss_pkg::CMD_SINGLE);
    chk("pen single", 1'h0, pen);
    chk("single start", mss_pkg::DEF_START, freq);
    wait_end();
    chk("blanks", 4, blanks);
    chk("fixed back", mss_pkg::DEF_FIXED, freq);
    chk("pen up", 1'h1, pen);
    chk("irq end", 1'h1, irq);
    rd(mss_pkg::OFF_IRQ_STAT, "irq stat", 32'h3);
    wr(mss_pkg::OFF_IRQ_STAT, 32'h3);
    chk("irq clear", 1'h0, irq);
    wr(mss_pkg::OFF_IRQ_MASK, '0);
    wr(mss_pkg::OFF_SWP_CMD, mss_pkg::CMD_AUTO);
    wait_end();
    chk("auto restart", mss_pkg::DEF_START, freq);
    chk("irq masked", 1'h0, irq);
    for (int n = 0; n < 600 && freq !== 20'h0_044C; n++) @(negedge i_clk);
    wr(mss_pkg::OFF_SWP_CMD, mss_pkg::CMD_MANUAL);
    f0 = freq;
    repeat (100) @(negedge i_clk);
    chk("manual hold", f0, freq);
    wr(mss_pkg::OFF_SWP_CMD, mss_pkg::CMD_AUTO);
    chk("resume", f0, freq);
    wr(mss_pkg::OFF_SWP_CMD, mss_pkg::CMD_MANUAL);
    f0 = freq;
    knob(1'h1);
    chk("knob up", f0 + 20'h0_0064, freq);
    knob(1'h0);
    chk("knob down", f0, freq);
    wr(mss_pkg::OFF_SWP_CMD, mss_pkg::CMD_CANCEL);
    rd(mss_pkg::OFF_STATUS, "cancel", 32'h3);
    wr(mss_pkg::OFF_SWP_CMD, mss_pkg::CMD_HOST);
    chk("host start", mss_pkg::DEF_START, freq);
    for (int i = 1; i < 4; i++) begin
      repeat (24) @(negedge i_clk);
      wr(mss_pkg::OFF_HOST_STP, 32'h1);
      chk("host freq", mss_pkg::DEF_START + 20'(i * 100), freq);
      chk("stair", i, stair);
    end
    repeat (24) @(negedge i_clk);
    // a new end pulse only once the previous one is over
    for (int n = 0; n < 2000 && endn !== 1'h1; n++) @(negedge i_clk);
    fork
      wr(mss_pkg::OFF_HOST_STP, 32'h1);
      wait_end();
    join
    chk("host end", 1'h0, endn);
    rear_pulse(3'h2, 16'h0514);
    chk("rear auto", 3'h1, q[5:3]);
    rear_pulse(3'h4, 16'h0064);
    chk("short ignored", 3'h1, q[5:3]);
    rear_pulse(3'h1, 16'h0514);
    chk("rear manual", 3'h2, q[5:3]);
    wr(mss_pkg::OFF_START, 20'h0_07D0);
    wr(mss_pkg::OFF_SPECIAL, mss_pkg::SF_SWP_DIS);
    rd(mss_pkg::OFF_START, "start dflt", mss_pkg::DEF_START);
    rd(mss_pkg::OFF_STOP, "stop dflt", mss_pkg::DEF_STOP);
    wr(mss_pkg::OFF_SWP_CMD, mss_pkg::CMD_AUTO);
    bus(1'h0, mss_pkg::OFF_STATUS, '0);
    chk("disabled", 4'h0, {q[5:3], q[0]});
    complete_run();
  end
endmodule
`default_nettype wire
